// *** i2c_bit_tracker.sv ***
// Bit counter and byte shifter that marks the 8th fall and 9th rise of a frame
`timescale 1ns/1ps
`default_nettype none
module i2c_bit_tracker
#(
   parameter int FRAME_BITS = i2c_irq_pkg::FRAME_BITS
)
(
   input wire logic clk,
   input wire logic reset,
   i2c_line_if.user line,
   output logic fall8_q,
   output logic rise9_q,
   output logic ack_level_q,
   output logic mid_byte_q,
   output logic [7:0] rx_byte_q
);
   logic [3:0] bit_cnt_q;
   logic [7:0] shift_q;

   if (FRAME_BITS != i2c_irq_pkg::FRAME_BITS)
   begin : g_bad_frame
      $error("Frame length other than 8 data bits plus acknowledge not supported");
   end

   // ****************************************
   // Bit position within the frame
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (reset || line.start_det || line.stop_det)
         bit_cnt_q <= i2c_irq_pkg::BIT_CNT_RESET;
      else if (line.scl_rise)
         bit_cnt_q <= (bit_cnt_q == i2c_irq_pkg::BIT_ACK) ? i2c_irq_pkg::BIT_FIRST
            : bit_cnt_q + 4'h1;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         shift_q <= 8'h00;
      else if (line.scl_rise && bit_cnt_q != i2c_irq_pkg::BIT_WAIT)
         shift_q <= {shift_q[6:0], line.sda_level};
   end

   // ****************************************
   // Registered frame events
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         fall8_q <= 1'h0;
         rise9_q <= 1'h0;
         ack_level_q <= 1'h0;
         mid_byte_q <= 1'h0;
         rx_byte_q <= 8'h00;
      end
      else
      begin
         fall8_q <= line.scl_fall && bit_cnt_q == i2c_irq_pkg::BIT_WAIT;
         rise9_q <= line.scl_rise && bit_cnt_q == i2c_irq_pkg::BIT_WAIT;
         // A stop after a whole frame follows its own clock rise, which opens a new frame count
         mid_byte_q <= bit_cnt_q > i2c_irq_pkg::BIT_FIRST
            && bit_cnt_q != i2c_irq_pkg::BIT_ACK;
         if (line.scl_rise && bit_cnt_q == i2c_irq_pkg::BIT_WAIT)
         begin
            ack_level_q <= line.sda_level;
            rx_byte_q <= shift_q;
         end
      end
   end
endmodule
`default_nettype wire

// *** i2c_bus_model.sv ***
// Behavioural far-side bus master that drives the clock and data lines
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_model
(
   output logic scl,
   output logic sda
);
   // ****************************************
   // Open-drain lines, high through pull-ups
   // ****************************************
   // Clock stands high while the bus is idle, as a real master leaves it
   initial
   begin
      scl = 1'h1;
      sda = 1'h1;
   end
   // Data moves mid-low so it is steady around each clock rise
   task automatic send(input logic [8:0] v, input int n);
      for (int i = 8; i > 8 - n; i--)
      begin
         sda = v[i];
         #80 scl = 1'h1;
         #160 scl = 1'h0;
         #80;
      end
   endtask
   task automatic start();
      sda = 1'h0;
      #160 scl = 1'h0;
      #80;
   endtask
   task automatic stop();
      sda = 1'h0;
      #80 scl = 1'h1;
      #160 sda = 1'h1;
      #160;
   endtask
endmodule
`default_nettype wire

// *** i2c_irq_flag_logic.sv ***
// Interrupt request flag logic of an I2C bus interface, master and slave
`timescale 1ns/1ps
`default_nettype none
module i2c_irq_flag_logic
#(
   parameter int ADDR_BITS = i2c_irq_pkg::ADDR_BITS
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic format_select,
   input wire logic wait_enable,
   input wire logic ack_check_enable,
   input wire logic lost_irq_enable,
   input wire logic end_irq_mask,
   input wire logic master_mode,
   input wire logic [ADDR_BITS-1:0] own_slave_addr_primary,
   input wire logic [ADDR_BITS-1:0] own_slave_addr_second,
   input wire logic start_issued,
   input wire logic arbitration_lost,
   input wire logic tx_write,
   input wire logic flag_read,
   input wire logic flag_write,
   input wire logic flag_wdata,
   input wire logic status_clear,
   output logic irq_request_flag,
   output logic bus_occupied_flag,
   output logic tx_buffer_empty,
   output logic received_ack_value,
   output logic arbitration_lost_flag,
   output logic match_primary_flag,
   output logic match_second_flag,
   output logic general_call_flag,
   output logic normal_end_seen,
   output logic illegal_end_seen,
   output logic [i2c_irq_pkg::VIEW_BITS-1:0] control_view
);
   if (ADDR_BITS != i2c_irq_pkg::ADDR_BITS)
   begin : g_bad_addr
      $error("Only seven-bit own addresses are supported");
   end

   // ****************************************
   // Line monitor and frame tracker
   // ****************************************
   i2c_line_if line ();
   logic fall8;
   logic rise9;
   logic ack_level;
   logic mid_byte;
   logic [7:0] rx_byte;

   i2c_line_monitor u_mon (
      .clk(clk),
      .reset(reset),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .line(line)
   );

   i2c_bit_tracker u_trk (
      .clk(clk),
      .reset(reset),
      .line(line),
      .fall8_q(fall8),
      .rise9_q(rise9),
      .ack_level_q(ack_level),
      .mid_byte_q(mid_byte),
      .rx_byte_q(rx_byte)
   );

   // ****************************************
   // State
   // ****************************************
   i2c_irq_pkg::frame_phase_t phase_q;
   logic irq_q;
   logic read_armed_q;
   logic busy_q;
   logic start_pending_q;
   logic lost_q;
   logic addressed_q;
   logic txe_q;
   logic ack_q;
   logic arb_q;
   logic aas_q;
   logic match_second_flag_q;
   logic gcall_q;
   logic stop_q;
   logic illegal_end_seen_q;

   logic i2c_fmt;
   logic master_eff;
   logic in_addr;
   logic hit_primary;
   logic hit_second;
   logic hit_gcall;
   logic ev_serial;
   logic ev_start;
   logic ev_wait;
   logic ev_end;
   logic ev_lost_addr;
   logic ev_nack;
   logic ev_arb;
   logic ev_match;
   logic ev_gcall;
   logic ev_slave_end;
   logic ev_stop;
   logic irq_set;
   logic irq_clr;

   function automatic logic addr_hit(input logic [7:0] b, input logic [ADDR_BITS-1:0] a);
      addr_hit = b[7:1] == a;
   endfunction

   assign i2c_fmt = ~format_select;
   assign master_eff = master_mode & ~lost_q;
   assign in_addr = phase_q == i2c_irq_pkg::PHASE_ADDR;
   assign hit_primary = addr_hit(rx_byte, own_slave_addr_primary);
   assign hit_second = addr_hit(rx_byte, own_slave_addr_second);
   assign hit_gcall = rx_byte == i2c_irq_pkg::GENERAL_CALL_BYTE;

   // ****************************************
   // Interrupt sources
   // ****************************************
   // Other serial format only reacts to start; its frame timing is elsewhere
   assign ev_serial = ~i2c_fmt & line.start_det;
   assign ev_start = i2c_fmt & master_eff & start_pending_q & line.start_det;
   assign ev_wait = i2c_fmt & master_eff & wait_enable & fall8;
   assign ev_end = i2c_fmt & master_eff & rise9;
   assign ev_lost_addr = i2c_fmt & lost_q & in_addr & rise9;
   assign ev_nack = i2c_fmt & ack_check_enable & rise9 & ack_level
      & (master_eff | addressed_q);
   assign ev_arb = i2c_fmt & master_eff & arbitration_lost & lost_irq_enable;
   assign ev_match = i2c_fmt & ~master_eff & in_addr & rise9
      & (hit_primary | hit_second);
   assign ev_gcall = i2c_fmt & ~master_eff & in_addr & rise9 & hit_gcall;
   assign ev_slave_end = i2c_fmt & ~master_eff & addressed_q & ~in_addr & rise9;
   assign ev_stop = i2c_fmt & ~master_eff & line.stop_det & ~end_irq_mask;

   assign irq_set = ev_serial | ev_start | ev_wait | ev_end | ev_lost_addr | ev_nack
      | ev_arb | ev_match | ev_gcall | ev_slave_end | ev_stop;
   assign irq_clr = flag_write & ~flag_wdata & read_armed_q;

   // ****************************************
   // Interrupt request flag
   // ****************************************
   // A set in the clearing cycle wins, so no event is lost
   always_ff @(posedge clk)
   begin
      if (reset)
         irq_q <= i2c_irq_pkg::IRQ_FLAG_RESET;
      else if (irq_set)
         irq_q <= 1'h1;
      else if (irq_clr)
         irq_q <= 1'h0;
   end

   always_ff @(posedge clk)
   begin
      if (reset || flag_write)
         read_armed_q <= 1'h0;
      else if (flag_read && irq_q)
         read_armed_q <= 1'h1;
   end

   // ****************************************
   // Bus occupancy and frame phase
   // ****************************************
   // No write path: software cannot disturb the occupancy view
   always_ff @(posedge clk)
   begin
      if (reset)
         busy_q <= i2c_irq_pkg::STATUS_RESET;
      else if (line.start_det)
         busy_q <= 1'h1;
      else if (line.stop_det)
         busy_q <= 1'h0;
   end

   always_ff @(posedge clk)
   begin
      if (reset || line.stop_det)
         phase_q <= i2c_irq_pkg::PHASE_IDLE;
      else if (line.start_det)
         phase_q <= i2c_irq_pkg::PHASE_ADDR;
      else
      begin
         case (phase_q)
            i2c_irq_pkg::PHASE_ADDR:
               if (rise9)
                  phase_q <= i2c_irq_pkg::PHASE_DATA;
            i2c_irq_pkg::PHASE_IDLE, i2c_irq_pkg::PHASE_DATA: ;
            default:
               phase_q <= i2c_irq_pkg::PHASE_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset || line.start_det || line.stop_det)
         addressed_q <= 1'h0;
      else if (ev_match || ev_gcall)
         addressed_q <= 1'h1;
   end

   // ****************************************
   // Master side state
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (reset)
         start_pending_q <= 1'h0;
      else if (start_issued)
         start_pending_q <= 1'h1;
      else if (line.start_det)
         start_pending_q <= 1'h0;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         lost_q <= 1'h0;
      else if (master_eff && arbitration_lost)
         lost_q <= 1'h1;
      else if (line.stop_det)
         lost_q <= 1'h0;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         txe_q <= i2c_irq_pkg::STATUS_RESET;
      else if (ev_start)
         txe_q <= 1'h1;
      else if (tx_write)
         txe_q <= 1'h0;
   end

   // Ack status shows only the last acknowledge, and stays 0 when unchecked
   always_ff @(posedge clk)
   begin
      if (reset || !ack_check_enable)
         ack_q <= i2c_irq_pkg::STATUS_RESET;
      else if (rise9 && (master_eff || addressed_q))
         ack_q <= ack_level;
   end

   // ****************************************
   // Sticky status flags
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (reset)
         arb_q <= i2c_irq_pkg::STATUS_RESET;
      else if (master_eff && arbitration_lost)
         arb_q <= 1'h1;
      else if (status_clear)
         arb_q <= 1'h0;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         aas_q <= i2c_irq_pkg::STATUS_RESET;
         match_second_flag_q <= i2c_irq_pkg::STATUS_RESET;
         gcall_q <= i2c_irq_pkg::STATUS_RESET;
      end
      else if (ev_match || ev_gcall)
      begin
         aas_q <= ev_match & hit_primary;
         match_second_flag_q <= ev_match & hit_second & ~hit_primary;
         gcall_q <= ev_gcall;
      end
      else if (status_clear || line.start_det || line.stop_det)
      begin
         aas_q <= 1'h0;
         match_second_flag_q <= 1'h0;
         gcall_q <= 1'h0;
      end
   end

   // Stop in the middle of a byte counts as illegal
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         stop_q <= i2c_irq_pkg::STATUS_RESET;
         illegal_end_seen_q <= i2c_irq_pkg::STATUS_RESET;
      end
      else if (ev_stop)
      begin
         stop_q <= ~mid_byte | stop_q;
         illegal_end_seen_q <= mid_byte | illegal_end_seen_q;
      end
      else if (status_clear)
      begin
         stop_q <= 1'h0;
         illegal_end_seen_q <= 1'h0;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign irq_request_flag = irq_q;
   assign bus_occupied_flag = busy_q;
   assign tx_buffer_empty = txe_q;
   assign received_ack_value = ack_q;
   assign arbitration_lost_flag = arb_q;
   assign match_primary_flag = aas_q;
   assign match_second_flag = match_second_flag_q;
   assign general_call_flag = gcall_q;
   assign normal_end_seen = stop_q;
   assign illegal_end_seen = illegal_end_seen_q;

   always_comb
   begin
      control_view = '0;
      control_view[i2c_irq_pkg::IRQ_FLAG_BIT] = irq_q;
      control_view[i2c_irq_pkg::BUSY_FLAG_BIT] = busy_q;
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_busy_follows_bus: assert property (
      (!line.start_det && !line.stop_det) |=> $stable(bus_occupied_flag))
      else $error("bus occupied changed without start or stop");
   chk_irq_has_cause: assert property (
      $rose(irq_request_flag) |-> $past(irq_set))
      else $error("irq flag rose without a source");
   chk_start_sets_both: assert property (
      ev_start |=> irq_request_flag && tx_buffer_empty)
      else $error("own start did not set irq and buffer empty");
   chk_wait_fall_irq: assert property (
      (i2c_fmt && master_eff && wait_enable && fall8) |=> irq_request_flag)
      else $error("wait at 8th fall did not raise irq");
   chk_end_rise_irq: assert property (
      (i2c_fmt && master_eff && rise9) |=> irq_request_flag)
      else $error("byte end did not raise irq");
   chk_lost_addr_irq: assert property (
      (i2c_fmt && lost_q && in_addr && rise9) |=> irq_request_flag)
      else $error("address after loss did not raise irq");
   chk_nack_status: assert property (
      (ack_check_enable && master_eff && rise9 && ack_level && i2c_fmt)
      |=> received_ack_value && irq_request_flag)
      else $error("nack in master mode not flagged");
   chk_arb_irq_set: assert property (
      (master_eff && arbitration_lost && lost_irq_enable && i2c_fmt)
      |=> arbitration_lost_flag && irq_request_flag)
      else $error("arbitration loss not flagged");
   chk_match_irq_set: assert property (
      ev_match |=> irq_request_flag && (match_primary_flag || match_second_flag))
      else $error("address match not flagged");
   chk_gcall_irq_set: assert property (
      ev_gcall |=> irq_request_flag && general_call_flag)
      else $error("general call not flagged");
   chk_stop_irq_set: assert property (
      ev_stop |=> irq_request_flag && (normal_end_seen || illegal_end_seen))
      else $error("stop not flagged");
   chk_write_one_keeps: assert property (
      (irq_request_flag && flag_write && flag_wdata) |=> irq_request_flag)
      else $error("writing one changed irq flag");
   chk_clear_after_read: assert property (
      (flag_read && !flag_write && irq_request_flag ##1 flag_write && !flag_wdata && !irq_set)
      |=> !irq_request_flag)
      else $error("read then write zero did not clear irq");

   cov_master_start: cover property (ev_start ##[1:1000] ev_end);
   cov_slave_match: cover property (ev_match ##[1:1000] ev_slave_end);
   cov_stop_seen: cover property (ev_stop);
   cov_flag_cleared: cover property (irq_request_flag ##1 irq_clr ##1 !irq_request_flag);
endmodule
`default_nettype wire

// *** i2c_irq_flag_logic_tb.sv ***
// Self-checking bench of the interrupt request flag logic
`timescale 1ns/1ps
`default_nettype none
module i2c_irq_flag_logic_tb;
   // ****************************************
   // Stimulus, partner and checks
   // ****************************************
   logic clk = 1'h0;
   logic reset = 1'h1;
   logic format_select, wait_enable, ack_check_enable, lost_irq_enable, end_irq_mask;
   logic master_mode, start_issued, arbitration_lost, tx_write, flag_read, flag_write;
   logic flag_wdata, status_clear;
   logic [6:0] addr1 = 7'h2A;
   logic [6:0] addr2 = 7'h35;
   logic irq, busy, txe, rack, lost, m1, m2, gc, nend, iend;
   logic [7:0] view;
   wire logic scl, sda;
   int bad_count = 0;
   int total_checks = 0;
   int cyc = 0;
   always #20 clk = ~clk;
   i2c_bus_model bus (.scl(scl), .sda(sda));
   i2c_irq_flag_logic dut (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda),
      .format_select(format_select), .wait_enable(wait_enable),
      .ack_check_enable(ack_check_enable), .lost_irq_enable(lost_irq_enable),
      .end_irq_mask(end_irq_mask), .master_mode(master_mode),
      .own_slave_addr_primary(addr1), .own_slave_addr_second(addr2),
      .start_issued(start_issued), .arbitration_lost(arbitration_lost),
      .tx_write(tx_write), .flag_read(flag_read), .flag_write(flag_write),
      .flag_wdata(flag_wdata), .status_clear(status_clear), .irq_request_flag(irq),
      .bus_occupied_flag(busy), .tx_buffer_empty(txe), .received_ack_value(rack),
      .arbitration_lost_flag(lost), .match_primary_flag(m1), .match_second_flag(m2),
      .general_call_flag(gc), .normal_end_seen(nend), .illegal_end_seen(iend),
      .control_view(view));
   task close_out();
      $display("checks %0d bad %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Whole run needs about 1160 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         bad_count++;
         close_out();
      end
   end
   task tick();
      @(posedge clk);
      #2;
   endtask
   task settle();
      repeat (8) tick();
   endtask
   task automatic pulse(ref logic s);
      s = 1'h1;
      tick();
      s = 1'h0;
   endtask
   task chk(input string name, input logic got, input logic exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %b seen %b", name, exp, got);
      end
   endtask
   // Read as one first, else the zero write is refused
   task clr();
      pulse(flag_read);
      flag_wdata = 1'h0;
      pulse(flag_write);
      tick();
   endtask
   task t_master();
      master_mode = 1'h1;
      pulse(start_issued);
      bus.start();
      settle();
      chk("irq", irq, 1'h1);
      chk("txe", txe, 1'h1);
      chk("busy", busy, 1'h1);
      chk("view", view === 8'h06, 1'h1);
      flag_wdata = 1'h1;
      pulse(flag_write);
      tick();
      flag_wdata = 1'h0;
      pulse(flag_write);
      tick();
      chk("irq", irq, 1'h1);
      chk("busy", busy, 1'h1);
      clr();
      chk("irq", irq, 1'h0);
      pulse(tx_write);
      chk("txe", txe, 1'h0);
      wait_enable = 1'h1;
      bus.send({8'hA0, 1'h0}, 8);
      settle();
      chk("irq", irq, 1'h1);
      clr();
      bus.send(9'h000, 1);
      settle();
      chk("irq", irq, 1'h1);
      clr();
      wait_enable = 1'h0;
      ack_check_enable = 1'h1;
      bus.send({8'h55, 1'h1}, 9);
      settle();
      chk("rack", rack, 1'h1);
      chk("irq", irq, 1'h1);
      clr();
      ack_check_enable = 1'h0;
      bus.send({8'h55, 1'h1}, 9);
      settle();
      chk("rack", rack, 1'h0);
      chk("irq", irq, 1'h1);
      clr();
      bus.stop();
      settle();
      chk("busy", busy, 1'h0);
      chk("irq", irq, 1'h0);
      $display("done master");
   endtask
   task t_lost();
      lost_irq_enable = 1'h1;
      pulse(start_issued);
      bus.start();
      settle();
      clr();
      pulse(arbitration_lost);
      settle();
      chk("lost", lost, 1'h1);
      chk("irq", irq, 1'h1);
      clr();
      master_mode = 1'h0;
      bus.send({8'h20, 1'h0}, 9);
      settle();
      chk("irq", irq, 1'h1);
      bus.stop();
      settle();
      clr();
      pulse(status_clear);
      lost_irq_enable = 1'h0;
      $display("done lost");
   endtask
   task t_slave();
      bus.start();
      settle();
      chk("irq", irq, 1'h0);
      bus.send({8'h54, 1'h0}, 9);
      settle();
      chk("m1", m1, 1'h1);
      chk("irq", irq, 1'h1);
      clr();
      bus.send({8'h3C, 1'h0}, 9);
      settle();
      chk("irq", irq, 1'h1);
      clr();
      ack_check_enable = 1'h1;
      bus.send({8'h3C, 1'h1}, 9);
      settle();
      chk("rack", rack, 1'h1);
      chk("irq", irq, 1'h1);
      clr();
      ack_check_enable = 1'h0;
      bus.stop();
      settle();
      chk("nend", nend, 1'h1);
      chk("irq", irq, 1'h1);
      chk("m1", m1, 1'h0);
      clr();
      pulse(status_clear);
      bus.start();
      bus.send({8'h6A, 1'h0}, 9);
      settle();
      chk("m2", m2, 1'h1);
      chk("irq", irq, 1'h1);
      clr();
      end_irq_mask = 1'h1;
      bus.stop();
      settle();
      chk("nend", nend, 1'h0);
      chk("irq", irq, 1'h0);
      end_irq_mask = 1'h0;
      bus.start();
      bus.send(9'h000, 9);
      settle();
      chk("gc", gc, 1'h1);
      chk("irq", irq, 1'h1);
      clr();
      bus.send({8'h77, 1'h0}, 9);
      settle();
      chk("irq", irq, 1'h1);
      clr();
      bus.send(9'h1FF, 3);
      bus.stop();
      settle();
      chk("iend", iend, 1'h1);
      chk("irq", irq, 1'h1);
      clr();
      pulse(status_clear);
      $display("done slave");
   endtask
   task t_format();
      format_select = 1'h1;
      bus.start();
      settle();
      chk("irq", irq, 1'h1);
      clr();
      bus.send({8'h54, 1'h0}, 9);
      settle();
      chk("irq", irq, 1'h0);
      bus.stop();
      settle();
      format_select = 1'h0;
      $display("done format");
   endtask
   initial
   begin
      {format_select, wait_enable, ack_check_enable, lost_irq_enable, end_irq_mask} = '0;
      {master_mode, start_issued, arbitration_lost, tx_write, flag_read} = '0;
      {flag_write, flag_wdata, status_clear} = '0;
      repeat (2) tick();
      reset = 1'h0;
      chk("irq", irq, 1'h0);
      chk("view", view === 8'h00, 1'h1);
      $display("done reset");
      t_master();
      t_lost();
      t_slave();
      t_format();
      close_out();
   end
endmodule
`default_nettype wire

// *** i2c_irq_pkg.sv ***
// Shared constants and types of the I2C interrupt request flag logic
package i2c_irq_pkg;
   // ****************************************
   // Flag positions and reset values
   // ****************************************
   localparam int IRQ_FLAG_BIT = 1;
   localparam int BUSY_FLAG_BIT = 2;
   localparam int VIEW_BITS = 8;
   localparam logic IRQ_FLAG_RESET = 1'h0;
   localparam logic STATUS_RESET = 1'h0;
   localparam logic LINE_IDLE = 1'h1;
   // ****************************************
   // Frame timing, counted in bus clocks
   // ****************************************
   localparam int FRAME_BITS = 9;
   localparam logic [3:0] BIT_CNT_RESET = 4'h0;
   localparam logic [3:0] BIT_WAIT = 4'h8;
   localparam logic [3:0] BIT_ACK = 4'h9;
   localparam logic [3:0] BIT_FIRST = 4'h1;
   localparam int ADDR_BITS = 7;
   localparam logic [7:0] GENERAL_CALL_BYTE = 8'h00;
   // ****************************************
   // Frame phase
   // ****************************************
   typedef enum logic [1:0] {PHASE_IDLE, PHASE_ADDR, PHASE_DATA} frame_phase_t;
endpackage

// *** i2c_line_if.sv ***
// Bus line events passed from the line monitor to the frame logic
`timescale 1ns/1ps
`default_nettype none
interface i2c_line_if;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic sda_level;
   modport mon (output scl_rise, output scl_fall, output start_det, output stop_det,
      output sda_level);
   modport user (input scl_rise, input scl_fall, input start_det, input stop_det,
      input sda_level);
endinterface
`default_nettype wire

// *** i2c_line_monitor.sv ***
// Synchroniser and start, stop and clock edge detector for the bus lines
`timescale 1ns/1ps
`default_nettype none
module i2c_line_monitor
(
   input wire logic clk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   i2c_line_if.mon line
);
   // ****************************************
   // Two-stage synchronisers
   // ****************************************
   logic scl_meta_q;
   logic sda_meta_q;
   logic scl_sync_q;
   logic sda_sync_q;
   logic scl_prev_q;
   logic sda_prev_q;

   // Lines idle high, so reset to high to avoid a false edge
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         scl_meta_q <= i2c_irq_pkg::LINE_IDLE;
         sda_meta_q <= i2c_irq_pkg::LINE_IDLE;
         scl_sync_q <= i2c_irq_pkg::LINE_IDLE;
         sda_sync_q <= i2c_irq_pkg::LINE_IDLE;
         scl_prev_q <= i2c_irq_pkg::LINE_IDLE;
         sda_prev_q <= i2c_irq_pkg::LINE_IDLE;
      end
      else
      begin
         scl_meta_q <= scl_in;
         sda_meta_q <= sda_in;
         scl_sync_q <= scl_meta_q;
         sda_sync_q <= sda_meta_q;
         scl_prev_q <= scl_sync_q;
         sda_prev_q <= sda_sync_q;
      end
   end

   // ****************************************
   // Edge and condition decode
   // ****************************************
   assign line.scl_rise = scl_sync_q & ~scl_prev_q;
   assign line.scl_fall = ~scl_sync_q & scl_prev_q;
   assign line.start_det = scl_sync_q & scl_prev_q & sda_prev_q & ~sda_sync_q;
   assign line.stop_det = scl_sync_q & scl_prev_q & ~sda_prev_q & sda_sync_q;
   assign line.sda_level = sda_sync_q;
endmodule
`default_nettype wire
